/* File: src/pffc_pkg.sv */
// Constants, encodings and byte layout for the pause frame flow control block
package pffc_pkg;
	localparam int N_CLASS = 8;
	localparam int QUANTA_W = 16;
	localparam int QUANTUM_BITS = 512;
	localparam int DATAPATH_BITS = 512;
	localparam int CYC_PER_QUANTUM = QUANTUM_BITS / DATAPATH_BITS;
	typedef enum logic [1:0] {PFFC_MODE_OFF, PFFC_MODE_STD, PFFC_MODE_PFC} pffc_mode_t;
	typedef enum logic {PFFC_GEN_IDLE, PFFC_GEN_SEND} pffc_gen_t;
	// Register word offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_HONOUR = 4'h1;
	localparam logic [3:0] REG_TX_QUANTA = 4'h2;
	localparam logic [3:0] REG_SW_REQ = 4'h3;
	localparam logic [3:0] REG_DADDR_L = 4'h4;
	localparam logic [3:0] REG_DADDR_H = 4'h5;
	localparam logic [3:0] REG_SADDR_L = 4'h6;
	localparam logic [3:0] REG_SADDR_H = 4'h7;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_TX_EN = 4'h9;
	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PROC_EN_BIT = 2;
	localparam int STAT_SENT_LSB = 8;
	localparam int STAT_BUSY_BIT = 16;
	// Reset values
	localparam logic [1:0] RST_MODE = 2'h1;
	localparam logic RST_PROC_EN = 1'b1;
	localparam logic RST_HONOUR = 1'b1;
	localparam logic [15:0] RST_TX_QUANTA = 16'hFFFF;
	localparam logic [7:0] RST_TX_EN = 8'hFF;
	localparam logic [47:0] RST_DADDR = 48'h010000C28001;
	localparam logic [47:0] RST_SADDR = 48'h000000000000;
	// Frame contents, byte indices from the destination address on
	localparam logic [47:0] PAUSE_DA = 48'h010000C28001;
	localparam logic [15:0] PAUSE_TYPE = 16'h8808;
	localparam logic [15:0] OP_STD = 16'h0001;
	localparam logic [15:0] OP_PFC = 16'h0101;
	localparam logic [5:0] IDX_SA = 6'h06;
	localparam logic [5:0] IDX_TYPE = 6'h0C;
	localparam logic [5:0] IDX_OP = 6'h0E;
	localparam logic [5:0] IDX_PARAM = 6'h10;
	localparam logic [5:0] IDX_TIME = 6'h12;
	localparam logic [5:0] IDX_TIME_END = 6'h22;
	localparam logic [5:0] IDX_LAST = 6'h3B;
endpackage

/* File: src/pffc_pause_timer.sv */
// One pause quanta countdown for a single traffic class
`timescale 1ns/100ps
module pffc_pause_timer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Load
	input wire logic load,
	input wire logic [pffc_pkg::QUANTA_W-1:0] load_val,
	// State
	output logic busy
);
	import pffc_pkg::*;
	logic [QUANTA_W-1:0] count_reg;
	logic [QUANTA_W-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (load)
			count_next = load_val;
		else if (count_reg != '0)
			count_next = count_reg - QUANTA_W'(CYC_PER_QUANTUM);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

	assign busy = count_reg != '0;

	property p_load_wins;
		@(posedge ref_clk) disable iff (!rst_n) load |=> count_reg == $past(load_val);
	endproperty
	a_load_wins: assert property (p_load_wins) else $error("pause count not replaced");
	property p_countdown;
		@(posedge ref_clk) disable iff (!rst_n) !load && count_reg != '0 |=> count_reg == $past(count_reg) - 16'h0001;
	endproperty
	a_countdown: assert property (p_countdown) else $error("pause count not decremented");
	property p_zero_resume;
		@(posedge ref_clk) disable iff (!rst_n) load && load_val == '0 |=> !busy;
	endproperty
	a_zero_resume: assert property (p_zero_resume) else $error("zero quanta did not resume");
endmodule // pffc_pause_timer

/* File: src/pffc_top.sv */
// Pause frame generation, pause reception and client stall for the transmit MAC
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module pffc_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Avalon-MM register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Client pause request and notification
	input wire logic [pffc_pkg::N_CLASS-1:0] pause_insert_tx,
	output logic [pffc_pkg::N_CLASS-1:0] pause_receive_rx,
	// Client transmit handshake
	input wire logic client_frame_active,
	output logic tx_client_ready,
	// Decoded incoming pause frame from the receive side
	input wire logic rx_pause_valid,
	input wire logic rx_pause_pfc,
	input wire logic [47:0] rx_pause_daddr,
	input wire logic [pffc_pkg::N_CLASS-1:0] rx_pause_class_en,
	input wire logic [pffc_pkg::N_CLASS*pffc_pkg::QUANTA_W-1:0] rx_pause_time,
	// Generated pause frame byte stream
	output logic gen_valid,
	output logic gen_sop,
	output logic gen_eop,
	output logic [7:0] gen_data,
	input wire logic gen_ready
);
	import pffc_pkg::*;

	// Builds one byte of the frame from destination address to the end of padding
	function automatic logic [7:0] frame_byte(input logic [5:0] idx, input logic pfc, input logic xoff,
		input logic [7:0] en, input logic [15:0] q, input logic [47:0] src);
		logic [7:0] b;
		logic [47:0] sh;
		logic [5:0] rel;
		logic [15:0] class_pause_time;
		b = 8'h00;
		sh = '0;
		rel = '0;
		class_pause_time = '0;
		if (idx < IDX_SA) begin
			sh = PAUSE_DA << {idx[2:0], 3'b000};
			b = sh[47:40];
		end else if (idx < IDX_TYPE) begin
			rel = idx - IDX_SA;
			sh = src << {rel[2:0], 3'b000};
			b = sh[47:40];
		end else if (idx == IDX_TYPE) begin
			b = PAUSE_TYPE[15:8];
		end else if (idx == IDX_TYPE + 6'h01) begin
			b = PAUSE_TYPE[7:0];
		end else if (idx == IDX_OP) begin
			b = pfc ? OP_PFC[15:8] : OP_STD[15:8];
		end else if (idx == IDX_OP + 6'h01) begin
			b = pfc ? OP_PFC[7:0] : OP_STD[7:0];
		end else if (!pfc) begin
			// XON carries zero quanta; padding follows as zeros
			if (idx == IDX_PARAM && xoff)
				b = q[15:8];
			else if (idx == IDX_PARAM + 6'h01 && xoff)
				b = q[7:0];
		end else if (idx == IDX_PARAM + 6'h01) begin
			b = en;
		end else if (idx >= IDX_TIME && idx < IDX_TIME_END) begin
			rel = (idx - IDX_TIME) >> 1;
			class_pause_time = (xoff && en[rel[2:0]]) ? q : 16'h0000;
			b = idx[0] ? class_pause_time[7:0] : class_pause_time[15:8];
		end
		return b;
	endfunction

	// Register state
	pffc_mode_t mode_reg, mode_next;
	logic proc_en_reg, proc_en_next;
	logic tx_pause_honour_ctrl_reg, tx_pause_honour_ctrl_next;
	logic [15:0] tx_quanta_reg, tx_quanta_next;
	logic [7:0] sw_req_reg, sw_req_next;
	logic [7:0] tx_en_reg, tx_en_next;
	logic [47:0] daddr_reg, daddr_next;
	logic [47:0] saddr_reg, saddr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wait_reg, wait_next;
	logic [31:0] rd_mux;
	logic wr_take;

	// Generator state
	pffc_gen_t gen_state_reg, gen_state_next;
	logic [5:0] gen_idx_reg, gen_idx_next;
	logic gen_xoff_reg, gen_xoff_next;
	logic [7:0] gen_en_reg, gen_en_next;
	logic [7:0] sent_reg, sent_next;
	logic gen_valid_reg, gen_valid_next;
	logic gen_sop_reg, gen_sop_next;
	logic gen_eop_reg, gen_eop_next;
	logic [7:0] gen_data_reg, gen_data_next;
	logic [7:0] req_eff;
	logic [7:0] need_on;
	logic [7:0] need_off;
	logic gen_start;

	// Receive state
	logic std_pend_reg, std_pend_next;
	logic [15:0] std_pend_val_reg, std_pend_val_next;
	logic [7:0] prx_reg, prx_next;
	logic ready_reg, ready_next;
	logic accept;
	logic [7:0] t_load;
	logic [15:0] t_val [N_CLASS];
	logic [7:0] t_busy;
	logic fc_on;

	assign fc_on = mode_reg == PFFC_MODE_STD || mode_reg == PFFC_MODE_PFC;
	assign wr_take = avs_write && !wait_reg;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			REG_CTRL: begin
				rd_mux[CTRL_MODE_LSB +: 2] = mode_reg;
				rd_mux[CTRL_PROC_EN_BIT] = proc_en_reg;
			end
			REG_HONOUR: rd_mux[0] = tx_pause_honour_ctrl_reg;
			REG_TX_QUANTA: rd_mux[15:0] = tx_quanta_reg;
			REG_SW_REQ: rd_mux[7:0] = sw_req_reg;
			REG_DADDR_L: rd_mux = daddr_reg[31:0];
			REG_DADDR_H: rd_mux[15:0] = daddr_reg[47:32];
			REG_SADDR_L: rd_mux = saddr_reg[31:0];
			REG_SADDR_H: rd_mux[15:0] = saddr_reg[47:32];
			REG_STATUS: begin
				rd_mux[7:0] = t_busy;
				rd_mux[STAT_SENT_LSB +: 8] = sent_reg;
				rd_mux[STAT_BUSY_BIT] = gen_state_reg == PFFC_GEN_SEND;
			end
			REG_TX_EN: rd_mux[7:0] = tx_en_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// One wait cycle per access keeps read data registered
	always_comb begin
		mode_next = mode_reg;
		proc_en_next = proc_en_reg;
		tx_pause_honour_ctrl_next = tx_pause_honour_ctrl_reg;
		tx_quanta_next = tx_quanta_reg;
		sw_req_next = sw_req_reg;
		tx_en_next = tx_en_reg;
		daddr_next = daddr_reg;
		saddr_next = saddr_reg;
		rdata_next = rdata_reg;
		wait_next = 1'b1;
		if ((avs_read || avs_write) && wait_reg) begin
			wait_next = 1'b0;
			rdata_next = avs_read ? rd_mux : 32'h0000_0000;
		end
		if (wr_take) begin
			unique case (avs_address)
				REG_CTRL: begin
					mode_next = pffc_mode_t'(avs_writedata[CTRL_MODE_LSB +: 2]);
					proc_en_next = avs_writedata[CTRL_PROC_EN_BIT];
				end
				REG_HONOUR: tx_pause_honour_ctrl_next = avs_writedata[0];
				REG_TX_QUANTA: tx_quanta_next = avs_writedata[15:0];
				REG_SW_REQ: sw_req_next = avs_writedata[7:0];
				REG_DADDR_L: daddr_next[31:0] = avs_writedata;
				REG_DADDR_H: daddr_next[47:32] = avs_writedata[15:0];
				REG_SADDR_L: saddr_next[31:0] = avs_writedata;
				REG_SADDR_H: saddr_next[47:32] = avs_writedata[15:0];
				REG_TX_EN: tx_en_next = avs_writedata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= pffc_mode_t'(RST_MODE);
			proc_en_reg <= RST_PROC_EN;
			tx_pause_honour_ctrl_reg <= RST_HONOUR;
			tx_quanta_reg <= RST_TX_QUANTA;
			sw_req_reg <= 8'h00;
			tx_en_reg <= RST_TX_EN;
			daddr_reg <= RST_DADDR;
			saddr_reg <= RST_SADDR;
			rdata_reg <= 32'h0000_0000;
			wait_reg <= 1'b1;
		end else begin
			mode_reg <= mode_next;
			proc_en_reg <= proc_en_next;
			tx_pause_honour_ctrl_reg <= tx_pause_honour_ctrl_next;
			tx_quanta_reg <= tx_quanta_next;
			sw_req_reg <= sw_req_next;
			tx_en_reg <= tx_en_next;
			daddr_reg <= daddr_next;
			saddr_reg <= saddr_next;
			rdata_reg <= rdata_next;
			wait_reg <= wait_next;
		end
	end

	// Request level against what the partner was last told
	assign req_eff = (pause_insert_tx | sw_req_reg) & tx_en_reg & (mode_reg == PFFC_MODE_STD ? 8'h01 : 8'hFF);
	assign need_on = req_eff & ~sent_reg;
	assign need_off = ~req_eff & sent_reg;
	assign gen_start = gen_state_reg == PFFC_GEN_IDLE && fc_on && !client_frame_active
		&& (need_on | need_off) != 8'h00;

	always_comb begin
		gen_state_next = gen_state_reg;
		gen_idx_next = gen_idx_reg;
		gen_xoff_next = gen_xoff_reg;
		gen_en_next = gen_en_reg;
		sent_next = fc_on ? sent_reg : 8'h00;
		gen_valid_next = gen_valid_reg;
		gen_sop_next = gen_sop_reg;
		gen_eop_next = gen_eop_reg;
		gen_data_next = gen_data_reg;
		unique case (gen_state_reg)
			PFFC_GEN_IDLE: begin
				if (gen_start) begin
					// XOFF first so a stop pending alongside a release goes out ahead of it; a stop raised during a release frame waits for it to end
					gen_state_next = PFFC_GEN_SEND;
					gen_idx_next = 6'h00;
					gen_xoff_next = need_on != 8'h00;
					gen_en_next = (need_on != 8'h00) ? need_on : need_off;
					gen_valid_next = 1'b1;
					gen_sop_next = 1'b1;
					gen_eop_next = 1'b0;
					gen_data_next = frame_byte(6'h00, mode_reg == PFFC_MODE_PFC, 1'b0, 8'h00, 16'h0000, saddr_reg);
				end
			end
			PFFC_GEN_SEND: begin
				if (gen_ready) begin
					gen_sop_next = 1'b0;
					if (gen_idx_reg == IDX_LAST) begin
						gen_state_next = PFFC_GEN_IDLE;
						gen_valid_next = 1'b0;
						gen_eop_next = 1'b0;
						sent_next = gen_xoff_reg ? (sent_reg | gen_en_reg) : (sent_reg & ~gen_en_reg);
					end else begin
						gen_idx_next = gen_idx_reg + 6'h01;
						gen_eop_next = gen_idx_next == IDX_LAST;
						gen_data_next = frame_byte(gen_idx_next, mode_reg == PFFC_MODE_PFC, gen_xoff_reg,
							gen_en_reg, tx_quanta_reg, saddr_reg);
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_state_reg <= PFFC_GEN_IDLE;
			gen_idx_reg <= 6'h00;
			gen_xoff_reg <= 1'b0;
			gen_en_reg <= 8'h00;
			sent_reg <= 8'h00;
			gen_valid_reg <= 1'b0;
			gen_sop_reg <= 1'b0;
			gen_eop_reg <= 1'b0;
			gen_data_reg <= 8'h00;
		end else begin
			gen_state_reg <= gen_state_next;
			gen_idx_reg <= gen_idx_next;
			gen_xoff_reg <= gen_xoff_next;
			gen_en_reg <= gen_en_next;
			sent_reg <= sent_next;
			gen_valid_reg <= gen_valid_next;
			gen_sop_reg <= gen_sop_next;
			gen_eop_reg <= gen_eop_next;
			gen_data_reg <= gen_data_next;
		end
	end

	// Incoming pause: gate, then load the class timers
	assign accept = rx_pause_valid && fc_on && proc_en_reg && rx_pause_daddr == daddr_reg
		&& (mode_reg == PFFC_MODE_PFC ? rx_pause_pfc
		: (!rx_pause_pfc && tx_pause_honour_ctrl_reg));

	always_comb begin
		std_pend_next = std_pend_reg;
		std_pend_val_next = std_pend_val_reg;
		t_load = 8'h00;
		for (int i = 0; i < N_CLASS; i++)
			t_val[i] = rx_pause_time[i*QUANTA_W +: QUANTA_W];
		if (!fc_on) begin
			// Leaving flow control drops any pause in force
			t_load = 8'hFF;
			for (int i = 0; i < N_CLASS; i++)
				t_val[i] = 16'h0000;
			std_pend_next = 1'b0;
		end else if (mode_reg == PFFC_MODE_PFC) begin
			std_pend_next = 1'b0;
			if (accept)
				t_load = rx_pause_class_en;
		end else begin
			// The frame on the wire completes before the stall begins
			if (accept) begin
				std_pend_next = 1'b1;
				std_pend_val_next = rx_pause_time[QUANTA_W-1:0];
			end
			if ((std_pend_reg || accept) && !client_frame_active) begin
				t_load[0] = 1'b1;
				t_val[0] = accept ? rx_pause_time[QUANTA_W-1:0] : std_pend_val_reg;
				std_pend_next = 1'b0;
			end
		end
		prx_next = mode_reg == PFFC_MODE_PFC ? t_busy : 8'h00;
		ready_next = !(mode_reg == PFFC_MODE_STD && (t_busy[0] || t_load[0]))
			&& gen_state_next == PFFC_GEN_IDLE;
	end

	// Timers run on the transmit MAC clock supplied from outside
	genvar g;
	generate
		for (g = 0; g < N_CLASS; g++) begin : g_timer
			pffc_pause_timer u_timer (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.load(t_load[g]),
				.load_val(t_val[g]),
				.busy(t_busy[g])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			std_pend_reg <= 1'b0;
			std_pend_val_reg <= 16'h0000;
			prx_reg <= 8'h00;
			ready_reg <= 1'b0;
		end else begin
			std_pend_reg <= std_pend_next;
			std_pend_val_reg <= std_pend_val_next;
			prx_reg <= prx_next;
			ready_reg <= ready_next;
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign pause_receive_rx = prx_reg;
	assign tx_client_ready = ready_reg;
	assign gen_valid = gen_valid_reg;
	assign gen_sop = gen_sop_reg;
	assign gen_eop = gen_eop_reg;
	assign gen_data = gen_data_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_off_silent;
		!fc_on && gen_state_reg == PFFC_GEN_IDLE |=> !gen_valid_reg;
	endproperty
	a_off_silent: assert property (p_off_silent) else $error("pause frame sent with flow control off");
	property p_da_first;
		gen_valid_reg && gen_sop_reg |-> gen_data_reg == PAUSE_DA[47:40] && gen_idx_reg == 6'h00;
	endproperty
	a_da_first: assert property (p_da_first) else $error("frame does not open with pause address");
	property p_type_hi;
		gen_valid_reg && gen_idx_reg == IDX_TYPE |-> gen_data_reg == 8'h88;
	endproperty
	a_type_hi: assert property (p_type_hi) else $error("wrong type byte");
	property p_opcode;
		gen_valid_reg && gen_idx_reg == IDX_OP |-> gen_data_reg == (mode_reg == PFFC_MODE_PFC ? 8'h01 : 8'h00);
	endproperty
	a_opcode: assert property (p_opcode) else $error("wrong opcode high byte");
	property p_xon_zero;
		gen_valid_reg && !gen_xoff_reg && gen_idx_reg >= IDX_PARAM + 6'h02 |-> gen_data_reg == 8'h00;
	endproperty
	a_xon_zero: assert property (p_xon_zero) else $error("XON carries nonzero time or pad");
	property p_frame_after;
		gen_start |-> !client_frame_active ##1 gen_valid_reg && gen_sop_reg;
	endproperty
	a_frame_after: assert property (p_frame_after) else $error("pause frame not started cleanly");
	property p_std_stall;
		mode_reg == PFFC_MODE_STD && t_busy[0] |=> !tx_client_ready;
	endproperty
	a_std_stall: assert property (p_std_stall) else $error("client not stalled during pause");
	property p_pfc_notify;
		mode_reg == PFFC_MODE_PFC && accept && rx_pause_class_en[0] && rx_pause_time[15:0] != 16'h0000
		##1 mode_reg == PFFC_MODE_PFC |=> pause_receive_rx[0];
	endproperty
	a_pfc_notify: assert property (p_pfc_notify) else $error("class pause not reported");
	property p_std_reject;
		mode_reg == PFFC_MODE_STD && !tx_pause_honour_ctrl_reg |-> !accept;
	endproperty
	a_std_reject: assert property (p_std_reject) else $error("pause honoured with honour bit clear");
	property p_bus_ack;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("bus access not acknowledged");

	c_xoff: cover property (gen_valid_reg && gen_eop_reg && gen_xoff_reg);
	c_xon: cover property (gen_valid_reg && gen_eop_reg && !gen_xoff_reg);
	c_std_pause: cover property (mode_reg == PFFC_MODE_STD && !tx_client_ready ##1 tx_client_ready);
	c_pfc_pause: cover property (pause_receive_rx[3] ##1 !pause_receive_rx[3]);
endmodule // pffc_top

/* File: tb/pffc_link_partner.sv */
// Link partner model: sends decoded pause frames and sinks the generated frame stream
`timescale 1ns/100ps
module pffc_link_partner (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Generated frame stream
	input wire logic gen_valid,
	input wire logic gen_sop,
	input wire logic gen_eop,
	input wire logic [7:0] gen_data,
	output logic gen_ready,
	// Decoded pause frames
	output logic rx_pause_valid,
	output logic rx_pause_pfc,
	output logic [47:0] rx_pause_daddr,
	output logic [7:0] rx_pause_class_en,
	output logic [127:0] rx_pause_time
);
	logic [7:0] frame [0:59];
	int idx = 0;
	int frames = 0;
	logic slow = 1'b0;
	logic tick = 1'b0;

	initial begin
		gen_ready = 1'b0;
		rx_pause_valid = 1'b0;
		rx_pause_pfc = 1'b0;
		rx_pause_daddr = 48'h0;
		rx_pause_class_en = 8'h00;
		rx_pause_time = 128'h0;
	end

	// A slow sink takes every second byte, so the generator must hold each byte
	always @(posedge ref_clk) begin
		tick <= ~tick;
		gen_ready <= rst_n & (~slow | tick);
		if (gen_valid && gen_ready) begin
			if (gen_sop) idx = 0;
			frame[idx] = gen_data;
			idx++;
			if (gen_eop) frames++;
		end
	end

	// Released address, class enables and times show the inverse, so stale values are never taken as fresh
	task automatic send(input logic pfc, input logic [47:0] da, input logic [7:0] en, input logic [127:0] t);
		@(posedge ref_clk);
		rx_pause_valid <= 1'b1;
		rx_pause_pfc <= pfc;
		rx_pause_daddr <= da;
		rx_pause_class_en <= en;
		rx_pause_time <= t;
		@(posedge ref_clk);
		rx_pause_valid <= 1'b0;
		rx_pause_daddr <= ~da;
		rx_pause_class_en <= ~en;
		rx_pause_time <= ~t;
	endtask
endmodule // pffc_link_partner

/* File: tb/pffc_top_bench.sv */
// Self-checking bench for the pause frame flow control block
`timescale 1ns/100ps
module pffc_top_bench;
	import pffc_pkg::*;
	localparam logic [47:0] DA = 48'h010000C28001;
	localparam logic [47:0] SA = 48'h112233445566;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] pause_insert_tx = 8'h00;
	logic [7:0] pause_receive_rx;
	logic client_frame_active = 1'b0;
	logic tx_client_ready, rx_pause_valid, rx_pause_pfc;
	logic [47:0] rx_pause_daddr;
	logic [7:0] rx_pause_class_en;
	logic [127:0] rx_pause_time;
	logic gen_valid, gen_sop, gen_eop, gen_ready;
	logic [7:0] gen_data;
	logic [31:0] rd;
	int mismatches = 0;
	int samples_checked = 0;
	int nf = 0;
	int lows;
	int hi [8];

	// Stands in for the PLL-fed transmit MAC clock
	always #50 ref_clk = ~ref_clk;

	pffc_top i_pffc_top (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .pause_insert_tx, .pause_receive_rx, .client_frame_active, .tx_client_ready,
		.rx_pause_valid, .rx_pause_pfc, .rx_pause_daddr, .rx_pause_class_en, .rx_pause_time,
		.gen_valid, .gen_sop, .gen_eop, .gen_data, .gen_ready);
	pffc_link_partner i_pffc_link_partner (.ref_clk, .rst_n, .gen_valid, .gen_sop, .gen_eop, .gen_data,
		.gen_ready, .rx_pause_valid, .rx_pause_pfc, .rx_pause_daddr, .rx_pause_class_en, .rx_pause_time);

	task automatic results;
		$display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Waitrequest and read data are registered, so the value seen at an edge is what that edge samples
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		logic ack;
		n = 0;
		ack = 1'b0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge ref_clk);
			n++;
			ack = (avs_waitrequest === 1'b0);
		end while (!ack && n < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (!ack) begin
			mismatches++;
			results();
		end
		@(posedge ref_clk);
	endtask

	task automatic watch(input int span);
		lows = 0;
		hi = '{default: 0};
		repeat (span) begin
			#1;
			if (tx_client_ready !== 1'b1) lows++;
			// Counts the cycles each class is reported paused
			for (int i = 0; i < 8; i++) if (pause_receive_rx[i] === 1'b1) hi[i]++;
			@(posedge ref_clk);
		end
	endtask

	task automatic frame(input logic [15:0] op, input logic [15:0] p, input logic [127:0] t);
		logic [7:0] e [0:59];
		int k;
		k = 0;
		nf++;
		while (i_pffc_link_partner.frames < nf && k < 400) begin
			@(posedge ref_clk);
			k++;
		end
		if (k == 400) begin
			mismatches++;
			results();
		end
		for (int i = 0; i < 60; i++) e[i] = 8'h00;
		for (int i = 0; i < 6; i++) begin
			e[i] = DA[47 - 8 * i -: 8];
			e[6 + i] = SA[47 - 8 * i -: 8];
		end
		e[12] = 8'h88;
		e[13] = 8'h08;
		e[14] = op[15:8];
		e[15] = op[7:0];
		e[16] = p[15:8];
		e[17] = p[7:0];
		for (int i = 0; i < 8; i++) begin
			e[18 + 2 * i] = t[16 * i + 15 -: 8];
			e[19 + 2 * i] = t[16 * i + 7 -: 8];
		end
		for (int i = 0; i < 60; i++) check("frame byte", {24'h0, e[i]}, {24'h0, i_pffc_link_partner.frame[i]});
	endtask

	task automatic t_regs;
		bus(1'b0, REG_CTRL, 32'h0);
		check("ctrl reset", 32'h00000005, rd);
		bus(1'b0, 4'hF, 32'h0);
		check("unmapped read", 32'h0, rd);
		bus(1'b1, REG_TX_QUANTA, 32'h00001234);
		bus(1'b1, REG_SADDR_L, 32'h33445566);
		bus(1'b1, REG_SADDR_H, 32'h00001122);
		bus(1'b0, REG_TX_QUANTA, 32'h0);
		check("quanta write", 32'h00001234, rd);
	endtask

	task automatic t_std_tx;
		int seen;
		seen = 0;
		i_pffc_link_partner.slow <= 1'b1;
		client_frame_active <= 1'b1;
		pause_insert_tx <= 8'h01;
		repeat (6) begin
			#1;
			if (gen_valid === 1'b1) seen++;
			@(posedge ref_clk);
		end
		check("frame held back", 0, seen);
		client_frame_active <= 1'b0;
		frame(16'h0001, 16'h1234, 128'h0);
		pause_insert_tx <= 8'h00;
		frame(16'h0001, 16'h0000, 128'h0);
		i_pffc_link_partner.slow <= 1'b0;
	endtask

	// Sends one standard pause that must be refused
	task automatic refused(input logic [47:0] da, input string what);
		i_pffc_link_partner.send(1'b0, da, 8'h00, 128'h5);
		watch(8);
		check(what, 0, lows);
	endtask

	task automatic t_std_rx;
		i_pffc_link_partner.send(1'b0, DA, 8'h00, 128'h5);
		watch(12);
		check("std pause length", 6, lows);
		i_pffc_link_partner.send(1'b0, DA, 8'h00, 128'h14);
		i_pffc_link_partner.send(1'b0, DA, 8'h00, 128'h0);
		watch(5);
		check("zero quanta resume", 1, lows);
		bus(1'b1, REG_HONOUR, 32'h0);
		refused(DA, "honour off");
		bus(1'b1, REG_HONOUR, 32'h1);
		refused(~DA, "address miss");
		bus(1'b1, REG_CTRL, 32'h1);
		refused(DA, "processing off");
		bus(1'b1, REG_CTRL, 32'h5);
		client_frame_active <= 1'b1;
		i_pffc_link_partner.send(1'b0, DA, 8'h00, 128'h3);
		watch(4);
		check("pause waits for frame", 0, lows);
		client_frame_active <= 1'b0;
		watch(8);
		check("pause after frame", 4, lows);
	endtask

	task automatic t_pfc;
		bus(1'b1, REG_CTRL, 32'h6);
		i_pffc_link_partner.send(1'b1, DA, 8'h05, {80'h0, 16'h6, 16'h7, 16'h3});
		watch(12);
		check("class 0 pause", 3, hi[0]);
		check("class 1 untouched", 0, hi[1]);
		check("class 2 pause", 6, hi[2]);
		check("client kept running", 0, lows);
		pause_insert_tx <= 8'h08;
		frame(16'h0101, 16'h0008, {64'h0, 16'h1234, 48'h0});
		pause_insert_tx <= 8'h00;
		frame(16'h0101, 16'h0008, 128'h0);
		bus(1'b1, REG_TX_EN, 32'h000000F7);
		pause_insert_tx <= 8'h08;
		bus(1'b1, REG_SW_REQ, 32'h00000010);
		frame(16'h0101, 16'h0010, {48'h0, 16'h1234, 64'h0});
		bus(1'b0, REG_STATUS, 32'h0);
		check("status sent", 32'h00001000, rd);
		bus(1'b1, REG_SW_REQ, 32'h00000000);
		frame(16'h0101, 16'h0010, 128'h0);
		pause_insert_tx <= 8'h00;
	endtask

	task automatic t_off(input logic [31:0] ctrl);
		bus(1'b1, REG_CTRL, ctrl);
		pause_insert_tx <= 8'h01;
		i_pffc_link_partner.send(1'b0, DA, 8'h00, 128'h5);
		watch(20);
		check("off no stall", 0, lows);
		check("off no frame", nf, i_pffc_link_partner.frames);
		pause_insert_tx <= 8'h00;
	endtask

	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_std_tx();
		t_std_rx();
		t_pfc();
		t_off(32'h4);
		t_off(32'h7);
		results();
	end
endmodule // pffc_top_bench
